/* File: bench/rae_enum_ctrl_bench.sv */
// Purpose: Self-checking bench for the enumeration controller
// Assumes: One pass per reset; fabric model re-armed by reset
// Notes: Random link and lock masks each pass; absence mask random from pass 2 on, zero before
`default_nettype none
module rae_enum_ctrl_bench;
	timeunit 1ns;
	timeprecision 100ps;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
	logic mnt_req, mnt_write, mnt_ack, mnt_err;
	logic [7:0] paddr, mnt_dest_id, mnt_hop;
	logic [31:0] pwdata, prdata, mnt_wdata, mnt_rdata;
	logic [23:0] mnt_offset;
	logic [15:0] link_ok, foreign, absent;
	logic [3:0] host_port, delay;
	int seed = 75;
	int fails = 0;
	int n_tests = 0;
	int cycles = 0;
	// Arbitrary identity value
	localparam logic [31:0] ident = 32'h0a0b0c0d;
	rae_enum_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq(irq), .mnt_req(mnt_req), .mnt_write(mnt_write),
		.mnt_dest_id(mnt_dest_id), .mnt_hop(mnt_hop), .mnt_offset(mnt_offset),
		.mnt_wdata(mnt_wdata), .mnt_ack(mnt_ack), .mnt_err(mnt_err), .mnt_rdata(mnt_rdata));
	rae_fabric_model #(.ident_value(ident)) fab (.pclk(pclk), .presetn(presetn), .mnt_req(mnt_req),
		.mnt_write(mnt_write), .mnt_dest_id(mnt_dest_id), .mnt_hop(mnt_hop),
		.mnt_offset(mnt_offset), .mnt_wdata(mnt_wdata), .link_ok(link_ok), .foreign(foreign),
		.absent(absent), .host_port(host_port), .delay(delay), .mnt_ack(mnt_ack),
		.mnt_err(mnt_err), .mnt_rdata(mnt_rdata));
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic run_pass(input int r);
		logic [31:0] q, st, res, rm;
		logic [63:0] map;
		logic [15:0] lk, fr, ab, fnd;
		logic [3:0] h;
		logic e;
		int okq[$];
		lk = 16'($random(seed));
		fr = lk & 16'($random(seed)) & 16'($random(seed));
		ab = (r > 1) ? lk & ~fr & 16'($random(seed)) & 16'($random(seed)) : 16'h0;
		h = 4'($random(seed));
		@(posedge pclk);
		link_ok <= lk;
		foreign <= fr;
		absent <= ab;
		host_port <= h;
		delay <= 4'(r);
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 8'h40, 32'h0, q, e);
		chk(q, 32'h0);
		chk({31'h0, e}, 32'h1);
		apb(1'b1, rae_pkg::apb_ctrl, {24'h0, h, 4'h1}, q, e);
		// Busy controller must ignore a second start
		if (r == 1)
			apb(1'b1, rae_pkg::apb_ctrl, {24'h0, ~h, 4'h1}, q, e);
		q = 32'h1;
		while (q[0] !== 1'b0)
			apb(1'b0, rae_pkg::apb_status, 32'h0, q, e);
		st = 32'h1;
		res = 32'h0;
		rm = '1;
		fnd = 16'h0;
		for (int p = 0; p < 16; p++)
		begin
			if (p == h || !lk[p])
				continue;
			if (ab[p])
			begin
				st[4] = 1'b1;
				rm[2*p +: 2] = 2'h0;
			end
			else if (fr[p])
			begin
				st[2] = 1'b1;
				res[2*p +: 2] = 2'h2;
			end
			else
			begin
				st[1] = 1'b1;
				res[2*p +: 2] = 2'h1;
				fnd[p] = 1'b1;
				okq.push_back(p);
			end
		end
		apb(1'b0, rae_pkg::apb_irq_status, 32'h0, q, e);
		chk(q, st);
		apb(1'b0, rae_pkg::apb_found, 32'h0, q, e);
		chk(q, {16'h0, fnd});
		apb(1'b0, rae_pkg::apb_next_id, 32'h0, q, e);
		chk(q, 32'(okq.size() + 1));
		apb(1'b0, rae_pkg::apb_last_ident, 32'h0, q, e);
		chk(q, ((lk & ~ab & ~(16'h1 << h)) != 16'h0) ? ident : 32'h0);
		apb(1'b0, rae_pkg::apb_ctrl, 32'h0, q, e);
		chk(q, {24'h0, h, 4'h0});
		apb(1'b0, rae_pkg::apb_port_result, 32'h0, q, e);
		chk(q & rm, res);
		apb(1'b0, rae_pkg::apb_port_map0, 32'h0, q, e);
		map[31:0] = q;
		apb(1'b0, rae_pkg::apb_port_map1, 32'h0, q, e);
		map[63:32] = q;
		foreach (okq[i])
			chk({28'h0, map[4*okq[i] +: 4]}, 32'(i + 1));
		apb(1'b1, rae_pkg::apb_irq_mask, 32'h0, q, e);
		@(negedge pclk);
		chk({31'h0, irq}, 32'h0);
		apb(1'b1, rae_pkg::apb_irq_mask, 32'h1f, q, e);
		@(negedge pclk);
		chk({31'h0, irq}, 32'h1);
		apb(1'b1, rae_pkg::apb_irq_status, 32'h1f, q, e);
		@(negedge pclk);
		chk({31'h0, irq}, 32'h0);
		$display("pass %0d done", r);
	endtask
	initial
	begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	always @(posedge pclk)
	begin
		cycles++;
		if (cycles == 40000)
		begin
			fails++;
			finish_test();
		end
	end
	initial
	begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{link_ok, foreign, absent, host_port, delay} = '0;
		for (int r = 0; r < 6; r++)
			run_pass(r);
		finish_test();
	end
endmodule
bind rae_enum_ctrl rae_enum_ctrl_monitor mon (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .irq(irq), .mnt_req(mnt_req), .mnt_write(mnt_write),
	.mnt_dest_id(mnt_dest_id), .mnt_hop(mnt_hop), .mnt_offset(mnt_offset),
	.mnt_wdata(mnt_wdata), .mnt_ack(mnt_ack), .mnt_err(mnt_err), .mnt_rdata(mnt_rdata));
`default_nettype wire

/* File: bench/rae_enum_ctrl_monitor.sv */
// Purpose: Port checks of the enumeration controller
// Assumes: Sees only the controller's top ports
// Notes: Maintenance fields are judged while a request is up
`default_nettype none
module rae_enum_ctrl_monitor (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic irq,
	input wire logic mnt_req,
	input wire logic mnt_write,
	input wire logic [7:0] mnt_dest_id,
	input wire logic [7:0] mnt_hop,
	input wire logic [23:0] mnt_offset,
	input wire logic [31:0] mnt_wdata,
	input wire logic mnt_ack,
	input wire logic mnt_err,
	input wire logic [31:0] mnt_rdata
);
	logic [23:0] last_off;
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			last_off <= 24'h000000;
		else if (mnt_req && mnt_ack)
			last_off <= mnt_offset;
	end
	a_req_hold: assert property (
		mnt_req && !mnt_ack |=> mnt_req && $stable({mnt_write, mnt_dest_id, mnt_hop, mnt_offset}))
		else $error("request changed before its answer");
	a_bad_addr: assert property (
		psel && penable && paddr > 8'h24 |-> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	a_switch_hop: assert property (
		mnt_req && (mnt_offset[7:4] == 4'h7 || mnt_offset >= 24'h000158) |-> mnt_hop == 8'h00)
		else $error("switch access without hop zero");
	a_agent_hop: assert property (
		mnt_req && mnt_offset <= 24'h000068 |-> mnt_hop == 8'hff)
		else $error("agent access without pass hop");
	a_route_order: assert property (
		$rose(mnt_req) && mnt_offset == 24'h000074 |-> last_off == 24'h000070)
		else $error("egress written without target first");
	a_lock_claim: assert property (
		mnt_req && mnt_write && mnt_offset == 24'h000068 |-> mnt_dest_id == 8'hff && mnt_wdata[15:0] == 16'h0)
		else $error("lock claim malformed");
	a_id_word: assert property (
		mnt_req && mnt_write && mnt_offset == 24'h000060 |-> mnt_wdata[31:24] == 8'h0
		&& mnt_wdata[23:16] == mnt_wdata[15:8] && mnt_wdata[7:0] == 8'h0 && mnt_dest_id == 8'hff)
		else $error("assigned id word malformed");
	a_skip_port: assert property (
		mnt_req && mnt_ack && !mnt_write && mnt_offset >= 24'h000158 && !mnt_rdata[1]
		|=> (!mnt_req || mnt_offset >= 24'h000158)[*3])
		else $error("dead port not skipped");
endmodule
`default_nettype wire

/* File: bench/rae_fabric_model.sv */
// Purpose: Switch plus one agent per port, answering maintenance requests
// Assumes: Reset re-arms every agent; host port has no agent
// Notes: Idle read data toggles so stale values never look valid
`default_nettype none
module rae_fabric_model #(
	parameter logic [31:0] ident_value = 32'h0a0b0c0d // Arbitrary
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic mnt_req,
	input wire logic mnt_write,
	input wire logic [7:0] mnt_dest_id,
	input wire logic [7:0] mnt_hop,
	input wire logic [23:0] mnt_offset,
	input wire logic [31:0] mnt_wdata,
	input wire logic [15:0] link_ok,
	input wire logic [15:0] foreign,
	input wire logic [15:0] absent,
	input wire logic [3:0] host_port,
	input wire logic [3:0] delay,
	output logic mnt_ack,
	output logic mnt_err,
	output logic [31:0] mnt_rdata
);
	logic [3:0] route [256];
	logic [31:0] lock [16];
	logic [31:0] small_system_id [16];
	logic [7:0] tgt;
	logic [3:0] pp;
	logic [23:0] st;
	int cnt;
	assign st = mnt_offset - 24'h000158;
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mnt_ack <= 1'b0;
			mnt_err <= 1'b0;
			mnt_rdata <= 32'h00000000;
			cnt = 0;
			tgt = 8'h00;
			for (int i = 0; i < 256; i++)
				route[i] = host_port;
			for (int i = 0; i < 16; i++)
			begin
				lock[i] = foreign[i] ? 32'h00000005 : 32'h0000ffff;
				small_system_id[i] = 32'h0000ff00;
			end
		end
		else
		begin
			mnt_ack <= 1'b0;
			mnt_err <= 1'b0;
			mnt_rdata <= ~mnt_rdata;
			if (mnt_req && !mnt_ack && cnt < delay)
				cnt++;
			else if (mnt_req && !mnt_ack)
			begin
				cnt = 0;
				mnt_ack <= 1'b1;
				if (mnt_hop == 8'h00)
				begin
					mnt_rdata <= 32'h0;
					if (mnt_write && mnt_offset == 24'h000070)
						tgt = mnt_wdata[7:0];
					if (mnt_write && mnt_offset == 24'h000074)
						route[tgt] = mnt_wdata[3:0];
					if (!mnt_write && st[4:0] == 5'h0 && st <= 24'h0001e0)
						mnt_rdata <= {30'h0, link_ok[st[8:5]], 1'b0};
				end
				else
				begin
					pp = route[mnt_dest_id];
					if (pp == host_port || !link_ok[pp] || absent[pp] || small_system_id[pp][15:8] != mnt_dest_id)
						mnt_err <= 1'b1;
					else if (mnt_offset == 24'h000000)
						mnt_rdata <= ident_value;
					else if (mnt_offset == 24'h000060 && mnt_write)
						small_system_id[pp] = mnt_wdata;
					else if (mnt_offset == 24'h000060)
						mnt_rdata <= small_system_id[pp];
					else if (mnt_write && lock[pp] == 32'h0000ffff)
						lock[pp] = {16'h0, mnt_wdata[15:0]};
					else if (!mnt_write)
						mnt_rdata <= lock[pp];
				end
			end
		end
	end
endmodule
`default_nettype wire

/* File: rtl/rae_apb_slave.sv */
// Purpose: APB slave decode and register storage for the enumeration controller
// Assumes: One aligned 32-bit word per register, zero wait states
// Notes: Unmapped addresses read zero and answer pslverr
`default_nettype none
module rae_apb_slave (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic busy,
	input wire logic [3:0] cur_port,
	input wire logic [7:0] next_id,
	input wire logic [15:0] found_mask,
	input wire logic [31:0] last_ident,
	input wire logic [31:0] port_results,
	input wire logic [63:0] port_map,
	input wire logic [rae_pkg::irq_width-1:0] irq_events,
	output logic start_pulse,
	output logic [3:0] host_port,
	output logic irq
);
	logic [rae_pkg::irq_width-1:0] irq_status;
	logic [rae_pkg::irq_width-1:0] irq_mask;
	logic wr_en;
	logic rd_en;
	logic mapped;

	assign pready = 1'b1;
	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && penable && !pwrite;
	assign irq = |(irq_status & irq_mask);

	always_comb
	begin
		mapped = 1'b1;
		prdata = 32'h00000000;
		if (paddr == rae_pkg::apb_ctrl)
			prdata = {24'h000000, host_port, 4'h0};
		else if (paddr == rae_pkg::apb_status)
			prdata = {24'h000000, cur_port, 3'h0, busy};
		else if (paddr == rae_pkg::apb_irq_status)
			prdata = {27'h0000000, irq_status};
		else if (paddr == rae_pkg::apb_irq_mask)
			prdata = {27'h0000000, irq_mask};
		else if (paddr == rae_pkg::apb_found)
			prdata = {16'h0000, found_mask};
		else if (paddr == rae_pkg::apb_next_id)
			prdata = {24'h000000, next_id};
		else if (paddr == rae_pkg::apb_last_ident)
			prdata = last_ident;
		else if (paddr == rae_pkg::apb_port_result)
			prdata = port_results;
		else if (paddr == rae_pkg::apb_port_map0)
			prdata = port_map[31:0];
		else if (paddr == rae_pkg::apb_port_map1)
			prdata = port_map[63:32];
		else
			mapped = 1'b0;
	end

	assign pslverr = psel && penable && !mapped;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			host_port <= 4'h0;
			start_pulse <= 1'b0;
		end
		else
		begin
			start_pulse <= wr_en && paddr == rae_pkg::apb_ctrl && pwdata[rae_pkg::ctrl_start_bit]
				&& !busy;
			if (wr_en && paddr == rae_pkg::apb_ctrl && !busy)
				host_port <= pwdata[rae_pkg::ctrl_host_port_lsb +: 4];
		end
	end

	// Set wins over write-one-to-clear
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq_status <= '0;
		else if (wr_en && paddr == rae_pkg::apb_irq_status)
			irq_status <= (irq_status & ~pwdata[rae_pkg::irq_width-1:0]) | irq_events;
		else
			irq_status <= irq_status | irq_events;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq_mask <= '0;
		else if (wr_en && paddr == rae_pkg::apb_irq_mask)
			irq_mask <= pwdata[rae_pkg::irq_width-1:0];
	end
endmodule
`default_nettype wire

/* File: rtl/rae_enum_ctrl.sv */
// Purpose: Host-side sequencer enumerating agents behind one switch
// Assumes: A maintenance engine outside takes one request at a time
// Notes: Software starts a pass over APB and reads results afterwards
`default_nettype none
module rae_enum_ctrl (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	output logic mnt_req,
	output logic mnt_write,
	output logic [7:0] mnt_dest_id,
	output logic [7:0] mnt_hop,
	output logic [23:0] mnt_offset,
	output logic [31:0] mnt_wdata,
	input wire logic mnt_ack,
	input wire logic mnt_err,
	input wire logic [31:0] mnt_rdata
);
	typedef enum logic [3:0] {
		st_idle = 4'h0,
		st_port_status = 4'h1,
		st_route_ff_id = 4'h2,
		st_route_ff_port = 4'h3,
		st_read_ident = 4'h4,
		st_read_lock = 4'h5,
		st_write_lock = 4'h6,
		st_confirm_lock = 4'h7,
		st_write_id = 4'h8,
		st_route_new_id = 4'h9,
		st_route_new_port = 4'ha,
		st_verify_id = 4'hb,
		st_next_port = 4'hc
	} rae_state_e;

	rae_state_e state;
	logic issued;
	logic [3:0] cur_port;
	logic [3:0] host_port;
	logic [7:0] next_id;
	logic [15:0] found_mask;
	logic [31:0] last_ident;
	logic [31:0] port_results;
	logic [63:0] port_map;
	logic [rae_pkg::irq_width-1:0] irq_events;
	logic start_pulse;
	logic busy;
	logic done_step;
	logic port_end;
	logic [3:0] final_port;

	function automatic logic [23:0] port_status_offset(input logic [3:0] port);
		return rae_pkg::off_port_zero_error_status + port * rae_pkg::port_status_stride;
	endfunction

	// Assigned ID register image, small and large fields
	function automatic logic [31:0] id_word(input logic [7:0] id);
		return ({24'h000000, id} << rae_pkg::small_id_lsb)
			| ({24'h000000, id} << rae_pkg::large_id_lsb);
	endfunction

	assign busy = state != st_idle;
	assign done_step = issued && mnt_ack;
	// Host on the top port pulls the last visited port down by one
	assign final_port = (host_port == rae_pkg::last_port) ? rae_pkg::last_port - 4'h1
		: rae_pkg::last_port;
	// Any way a port can finish: error, skip, refused lock or verify
	assign port_end = done_step && (mnt_err || state == st_verify_id
		|| (state == st_port_status && !mnt_rdata[rae_pkg::port_link_ok_bit])
		|| (state == st_read_lock && mnt_rdata != rae_pkg::host_lock_unlocked)
		|| (state == st_confirm_lock && mnt_rdata[15:0] != {8'h00, rae_pkg::host_own_id}));

	rae_apb_slave u_apb (
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.busy(busy),
		.cur_port(cur_port),
		.next_id(next_id),
		.found_mask(found_mask),
		.last_ident(last_ident),
		.port_results(port_results),
		.port_map(port_map),
		.irq_events(irq_events),
		.start_pulse(start_pulse),
		.host_port(host_port),
		.irq(irq)
	);

	// Request held until the engine acknowledges
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			issued <= 1'b0;
		else if (done_step)
			issued <= 1'b0;
		else if (busy && state != st_next_port)
			issued <= 1'b1;
	end

	assign mnt_req = issued;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mnt_write <= 1'b0;
			mnt_dest_id <= 8'h00;
			mnt_hop <= 8'h00;
			mnt_offset <= 24'h000000;
			mnt_wdata <= 32'h00000000;
		end
		else if (!issued)
		begin
			mnt_write <= 1'b0;
			mnt_dest_id <= rae_pkg::default_agent_id;
			mnt_hop <= rae_pkg::hop_pass;
			mnt_wdata <= 32'h00000000;
			mnt_offset <= rae_pkg::off_identity_capability;
			case (state)
				st_port_status:
				begin
					mnt_hop <= rae_pkg::hop_switch;
					mnt_offset <= port_status_offset(cur_port);
				end
				st_route_ff_id, st_route_new_id:
				begin
					mnt_write <= 1'b1;
					mnt_hop <= rae_pkg::hop_switch;
					mnt_offset <= rae_pkg::off_route_update_target_id;
					// Default ID, or next_id in st_route_new_id, steered to this port
					mnt_wdata <= {24'h000000, state == st_route_ff_id ?
						rae_pkg::default_agent_id : next_id};
				end
				st_route_ff_port, st_route_new_port:
				begin
					mnt_write <= 1'b1;
					mnt_hop <= rae_pkg::hop_switch;
					mnt_offset <= rae_pkg::off_route_update_egress;
					mnt_wdata <= {28'h0000000, cur_port};
				end
				st_read_ident:
					mnt_offset <= rae_pkg::off_identity_capability;
				st_read_lock, st_confirm_lock:
					mnt_offset <= rae_pkg::off_configuring_host_lock;
				st_write_lock:
				begin
					mnt_write <= 1'b1;
					mnt_offset <= rae_pkg::off_configuring_host_lock;
					mnt_wdata <= {24'h000000, rae_pkg::host_own_id};
				end
				st_write_id:
				begin
					mnt_write <= 1'b1;
					mnt_offset <= rae_pkg::off_assigned_id_register;
					mnt_wdata <= id_word(next_id);
				end
				st_verify_id:
				begin
					// Address the agent by its new ID
					mnt_dest_id <= next_id;
					mnt_offset <= rae_pkg::off_assigned_id_register;
				end
				default:
					mnt_wdata <= 32'h00000000;
			endcase
		end
	end

	// Past st_idle and st_next_port, the sequencer advances only on an answer
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			state <= st_idle;
		else if (state == st_idle)
		begin
			if (start_pulse)
				state <= st_next_port;
		end
		else if (state == st_next_port)
			state <= st_port_status;
		else if (done_step && mnt_err)
			state <= (cur_port == final_port) ? st_idle : st_next_port;
		else if (done_step)
		begin
			case (state)
				st_port_status:
					if (mnt_rdata[rae_pkg::port_link_ok_bit])
						state <= st_route_ff_id;
					else
						state <= (cur_port == final_port) ? st_idle : st_next_port;
				st_route_ff_id:
					state <= st_route_ff_port;
				st_route_ff_port:
					state <= st_read_ident;
				st_read_ident:
					state <= st_read_lock;
				st_read_lock:
					if (mnt_rdata == rae_pkg::host_lock_unlocked)
						state <= st_write_lock;
					else
						state <= (cur_port == final_port) ? st_idle : st_next_port;
				st_write_lock:
					state <= st_confirm_lock;
				st_confirm_lock:
					if (mnt_rdata[15:0] == {8'h00, rae_pkg::host_own_id})
						state <= st_write_id;
					else
						state <= (cur_port == final_port) ? st_idle : st_next_port;
				st_write_id:
					state <= st_route_new_id;
				st_route_new_id:
					state <= st_route_new_port;
				st_route_new_port:
					state <= st_verify_id;
				default:
					state <= (cur_port == final_port) ? st_idle : st_next_port;
			endcase
		end
	end

	// Walk ports, skipping the host's own
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cur_port <= 4'h0;
		else if (state == st_idle && start_pulse)
			cur_port <= (host_port == 4'h0) ? 4'h1 : 4'h0;
		else if (state == st_next_port && cur_port == host_port)
			cur_port <= cur_port + 4'h1;
		else if (port_end && cur_port != final_port)
			cur_port <= (cur_port + 4'h1 == host_port && host_port != rae_pkg::last_port) ?
				cur_port + 4'h2 : cur_port + 4'h1;
	end

	// IDs ascend from one per error-free verify answer, matching or not
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			next_id <= rae_pkg::first_agent_id;
		else if (state == st_idle && start_pulse)
			next_id <= rae_pkg::first_agent_id;
		else if (done_step && !mnt_err && state == st_verify_id)
			next_id <= next_id + 8'h01;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			found_mask <= 16'h0000;
			last_ident <= 32'h00000000;
			port_results <= 32'h00000000;
			port_map <= 64'h0;
		end
		else if (state == st_idle && start_pulse)
		begin
			found_mask <= 16'h0000;
			port_results <= 32'h00000000;
			port_map <= 64'h0;
		end
		else if (done_step && !mnt_err)
		begin
			if (state == st_read_ident)
				last_ident <= mnt_rdata;
			if (state == st_read_lock && mnt_rdata != rae_pkg::host_lock_unlocked)
				port_results[cur_port*2 +: 2] <= rae_pkg::res_lock;
			if (state == st_confirm_lock
				&& mnt_rdata[15:0] != {8'h00, rae_pkg::host_own_id})
				port_results[cur_port*2 +: 2] <= rae_pkg::res_lock;
			if (state == st_verify_id)
			begin
				port_map[cur_port*4 +: 4] <= next_id[3:0];
				if (mnt_rdata == id_word(next_id))
				begin
					found_mask[cur_port] <= 1'b1;
					port_results[cur_port*2 +: 2] <= rae_pkg::res_ok;
				end
				else
					port_results[cur_port*2 +: 2] <= rae_pkg::res_fail;
			end
		end
	end

	always_comb
	begin
		irq_events = '0;
		irq_events[rae_pkg::irq_done] = port_end && cur_port == final_port;
		irq_events[rae_pkg::irq_agent] = done_step && !mnt_err && state == st_verify_id
			&& mnt_rdata == id_word(next_id);
		irq_events[rae_pkg::irq_verify_fail] = done_step && !mnt_err && state == st_verify_id
			&& mnt_rdata != id_word(next_id);
		irq_events[rae_pkg::irq_lock_fail] = done_step && !mnt_err
			&& ((state == st_read_lock && mnt_rdata != rae_pkg::host_lock_unlocked)
			|| (state == st_confirm_lock && mnt_rdata[15:0] != {8'h00, rae_pkg::host_own_id}));
		irq_events[rae_pkg::irq_maint_err] = done_step && mnt_err;
	end
endmodule
`default_nettype wire

/* File: rtl/rae_pkg.sv */
// Purpose: Shared constants for the agent enumeration controller
// Assumes: Single switch, single host, small transport IDs
// Notes: Maintenance offsets are device byte offsets; APB offsets are our own
`default_nettype none
package rae_pkg;
	// Device maintenance map
	localparam logic [23:0] off_identity_capability = 24'h000000;
	localparam logic [23:0] off_assigned_id_register = 24'h000060;
	localparam logic [23:0] off_configuring_host_lock = 24'h000068;
	localparam logic [23:0] off_route_update_target_id = 24'h000070;
	localparam logic [23:0] off_route_update_egress = 24'h000074;
	localparam logic [23:0] off_port_zero_error_status = 24'h000158;
	localparam logic [23:0] port_status_stride = 24'h000020;
	localparam logic [31:0] host_lock_unlocked = 32'h0000ffff;
	localparam logic [7:0] default_agent_id = 8'hff;
	localparam logic [7:0] host_own_id = 8'h00;
	localparam logic [7:0] hop_switch = 8'h00;
	localparam logic [7:0] hop_pass = 8'hff;
	localparam logic [7:0] first_agent_id = 8'h01;
	localparam logic [3:0] last_port = 4'hf;
	// Link-ok bit position in port error and status register
	localparam int port_link_ok_bit = 1;
	localparam int small_id_lsb = 8;
	localparam int large_id_lsb = 16;
	// APB register byte offsets
	localparam logic [7:0] apb_ctrl = 8'h00;
	localparam logic [7:0] apb_status = 8'h04;
	localparam logic [7:0] apb_irq_status = 8'h08;
	localparam logic [7:0] apb_irq_mask = 8'h0c;
	localparam logic [7:0] apb_found = 8'h10;
	localparam logic [7:0] apb_next_id = 8'h14;
	localparam logic [7:0] apb_last_ident = 8'h18;
	localparam logic [7:0] apb_port_result = 8'h1c;
	localparam logic [7:0] apb_port_map0 = 8'h20;
	localparam logic [7:0] apb_port_map1 = 8'h24;
	// Control fields
	localparam int ctrl_start_bit = 0;
	localparam int ctrl_host_port_lsb = 4;
	// Interrupt bits
	localparam int irq_done = 0;
	localparam int irq_agent = 1;
	localparam int irq_lock_fail = 2;
	localparam int irq_verify_fail = 3;
	localparam int irq_maint_err = 4;
	localparam int irq_width = 5;
	// Per-port result codes
	localparam logic [1:0] res_none = 2'h0;
	localparam logic [1:0] res_ok = 2'h1;
	localparam logic [1:0] res_lock = 2'h2;
	localparam logic [1:0] res_fail = 2'h3;
endpackage
`default_nettype wire
